// *** smcp_defs.svh ***
// constants for the serial mode command protocol block
`ifndef SMCP_DEFS_SVH
`define SMCP_DEFS_SVH

// clock and serial timing
`define SMCP_CLK_HZ         10000000
`define SMCP_BAUD           38400
`define SMCP_BIT_CYC        (`SMCP_CLK_HZ / `SMCP_BAUD)
`define SMCP_HALF_CYC       (`SMCP_BIT_CYC / 2)
`define SMCP_DATA_BITS      8
`define SMCP_REPORT_MS      200
`define SMCP_REPORT_CYC     (`SMCP_CLK_HZ / 1000 * `SMCP_REPORT_MS)

// command bytes
`define SMCP_PREFIX         8'h9D
`define SMCP_CODE_FULL      8'h54
`define SMCP_CODE_QUIET     8'h00
`define SMCP_CODE_FLOW      8'h56
`define SMCP_CODE_LOOKUP    8'h55

// message lengths in bytes
`define SMCP_LEN_ANN_FULL   26
`define SMCP_LEN_ANN_QUIET  19
`define SMCP_LEN_ANN_FLOW   23
`define SMCP_LEN_LOOKUP     27
`define SMCP_LEN_FRM_FULL   25
`define SMCP_LEN_FRM_FLOW   13

// digit field positions inside messages
`define SMCP_FULL_VOLT_POS  2
`define SMCP_FULL_FLOW_POS  10
`define SMCP_FLOW_FLOW_POS  2
`define SMCP_LOOK_FLOW_POS  0
`define SMCP_VOLT_DIGITS    5
`define SMCP_FLOW_DIGITS    8
`define SMCP_ASCII_ZERO     8'h30

// reset values
`define SMCP_RESET_MODE     2'b00

`endif

// *** smcp_host.sv ***
// serial host model: sends command bytes and collects the bytes sent back
`timescale 1ns/1ps
`include "smcp_defs.svh"
module smcp_host
(
  input  wire logic i_mclk,
  input  wire logic i_tx,
  output logic      o_rx
);
  logic [7:0] rxq[$];
  logic [7:0] sh;

  initial o_rx = 1'b1;

  // one 8n1 byte, lsb first, no parity, changed on falling edges
  task automatic send(input logic [7:0] b);
    @(negedge i_mclk);
    o_rx = 1'b0;
    repeat (`SMCP_BIT_CYC) @(negedge i_mclk);
    for (int k = 0; k < 8; k++)
    begin
      o_rx = b[k];
      repeat (`SMCP_BIT_CYC) @(negedge i_mclk);
    end
    o_rx = 1'b1;
    repeat (`SMCP_BIT_CYC) @(negedge i_mclk);
  endtask

  // pause of over 5 ms between two command bytes
  task automatic gap();
    repeat (50100) @(negedge i_mclk);
  endtask

  // receiver: samples mid bit, keeps bytes with a good stop bit
  always
  begin
    @(negedge i_tx);
    repeat (`SMCP_HALF_CYC) @(posedge i_mclk);
    for (int k = 0; k < 8; k++)
    begin
      repeat (`SMCP_BIT_CYC) @(posedge i_mclk);
      sh[k] = i_tx;
    end
    repeat (`SMCP_BIT_CYC) @(posedge i_mclk);
    if (i_tx === 1'b1)
      rxq.push_back(sh);
  end
endmodule

// *** smcp_pkg.sv ***
// types for the serial mode command protocol block
package smcp_pkg;

  typedef enum logic [1:0] {
    SMCP_MODE_QUIET = 2'b00,
    SMCP_MODE_FULL  = 2'b01,
    SMCP_MODE_FLOW  = 2'b10
  } smcp_mode_t;

  typedef enum logic [0:0] {
    SMCP_CMD_IDLE  = 1'b0,
    SMCP_CMD_ARMED = 1'b1
  } smcp_cmd_st_t;

  typedef enum logic [2:0] {
    SMCP_MSG_ANN_FULL  = 3'b000,
    SMCP_MSG_ANN_QUIET = 3'b001,
    SMCP_MSG_ANN_FLOW  = 3'b010,
    SMCP_MSG_LOOKUP    = 3'b011,
    SMCP_MSG_FRM_FULL  = 3'b100,
    SMCP_MSG_FRM_FLOW  = 3'b101
  } smcp_msg_t;

  typedef enum logic [1:0] {
    SMCP_UART_IDLE  = 2'b00,
    SMCP_UART_START = 2'b01,
    SMCP_UART_DATA  = 2'b10,
    SMCP_UART_STOP  = 2'b11
  } smcp_uart_st_t;

  // measurement carried into a frame: bcd digits, most significant first
  typedef struct packed {
    logic [31:0] flow;
    logic [19:0] volt;
  } smcp_meas_t;

endpackage

// *** smcp_top.sv ***
// serial command interpreter: mode selection, echo, announcements, reports
`timescale 1ns/1ps
`include "smcp_defs.svh"
module smcp_top
  import smcp_pkg::*;
#(
  parameter int REPORT_CYC = `SMCP_REPORT_CYC
)
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_rx,
  input  wire smcp_meas_t i_meas,
  output logic            o_tx,
  output smcp_mode_t      o_mode,
  output logic            o_msg_busy
);

  localparam logic [8*`SMCP_LEN_ANN_FULL-1:0]  TXT_ANN_FULL  = "IN OPERATION MODE ......\n\r";
  localparam logic [8*`SMCP_LEN_ANN_QUIET-1:0] TXT_ANN_QUIET = "IN USER MODE.....\n\r";
  localparam logic [8*`SMCP_LEN_ANN_FLOW-1:0]  TXT_ANN_FLOW  = "IN CUSTOMER MODE.....\n\r";
  localparam logic [8*`SMCP_LEN_LOOKUP-1:0]    TXT_LOOKUP    = "00000000IN USER MODE.....\n\r";
  localparam logic [8*`SMCP_LEN_FRM_FULL-1:0]  TXT_FRM_FULL  = "V=00000\nF=00000000\nA=0\n;\n";
  localparam logic [8*`SMCP_LEN_FRM_FLOW-1:0]  TXT_FRM_FLOW  = "F=00000000\n;\n";
  localparam logic [20:0] RPT_LAST = 21'(REPORT_CYC - 1);
  localparam int          TXT_W    = 8*`SMCP_LEN_LOOKUP;

  smcp_cmd_st_t cmd_st;
  smcp_mode_t   mode;
  smcp_msg_t    cmd_kind;
  smcp_msg_t    msg_kind;
  smcp_meas_t   snap;
  logic         cmd_pend;
  logic         echo_pend;
  logic [7:0]   echo_byte;
  logic         msg_busy;
  logic [4:0]   msg_idx;
  logic [4:0]   msg_last;
  logic [7:0]   msg_byte;
  logic         frame_due;
  logic [20:0]  rpt_cnt;
  logic         rpt_wrap;
  logic         rx_valid;
  logic [7:0]   rx_data;
  logic         tx_valid;
  logic         tx_ready;
  logic [7:0]   tx_data;
  logic         tx_fire;
  logic         code_ok;
  logic         accept;
  logic         prefix_hit;
  logic         start_cmd;
  logic         start_frame;
  smcp_mode_t   next_mode;
  smcp_msg_t    next_kind;

  smcp_uart u_uart (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_rx       (i_rx),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .i_tx_valid (tx_valid),
    .i_tx_data  (tx_data),
    .o_tx_ready (tx_ready),
    .o_tx       (o_tx)
  );
  // byte i of a text of length len, texts widened to the longest one
  function automatic logic [7:0] pick(input logic [TXT_W-1:0] s,
                                      input int len, input logic [4:0] i);
    return s[8*(len-1-int'(i)) +: 8];
  endfunction
  function automatic logic [7:0] flow_chr(input logic [31:0] f, input int n);
    return `SMCP_ASCII_ZERO + {4'h0, f[4*(`SMCP_FLOW_DIGITS-1-n) +: 4]};
  endfunction
  function automatic logic [7:0] volt_chr(input logic [19:0] v, input int n);
    return `SMCP_ASCII_ZERO + {4'h0, v[4*(`SMCP_VOLT_DIGITS-1-n) +: 4]};
  endfunction

  always_comb
  begin
    code_ok   = 1'b1;
    next_mode = mode;
    next_kind = SMCP_MSG_ANN_QUIET;
    case (rx_data)
      `SMCP_CODE_FULL:
      begin
        next_mode = SMCP_MODE_FULL;
        next_kind = SMCP_MSG_ANN_FULL;
      end
      `SMCP_CODE_QUIET:
      begin
        next_mode = SMCP_MODE_QUIET;
        next_kind = SMCP_MSG_ANN_QUIET;
      end
      `SMCP_CODE_FLOW:
      begin
        next_mode = SMCP_MODE_FLOW;
        next_kind = SMCP_MSG_ANN_FLOW;
      end
      `SMCP_CODE_LOOKUP:
      begin
        next_mode = SMCP_MODE_QUIET;
        next_kind = SMCP_MSG_LOOKUP;
      end
      default:
        code_ok = 1'b0;
    endcase
  end

  assign prefix_hit = rx_valid && (cmd_st == SMCP_CMD_IDLE) && (rx_data == `SMCP_PREFIX);
  assign accept     = rx_valid && (cmd_st == SMCP_CMD_ARMED) && code_ok;
  // prefix then code; any other byte returns to idle silently
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      cmd_st <= SMCP_CMD_IDLE;
    else if (prefix_hit)
      cmd_st <= SMCP_CMD_ARMED;
    else if (rx_valid)
      cmd_st <= SMCP_CMD_IDLE;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      mode <= smcp_mode_t'(`SMCP_RESET_MODE);
    else if (accept)
      mode <= next_mode;
  end
  // echo has priority over message bytes; a new byte wins over the clear
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      echo_pend <= 1'b0;
      echo_byte <= 8'h00;
    end
    else if (prefix_hit || accept)
    begin
      echo_pend <= 1'b1;
      echo_byte <= rx_data;
    end
    else if (tx_fire && echo_pend)
      echo_pend <= 1'b0;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      cmd_pend <= 1'b0;
      cmd_kind <= SMCP_MSG_ANN_QUIET;
    end
    else if (accept)
    begin
      cmd_pend <= 1'b1;
      cmd_kind <= next_kind;
    end
    else if (start_cmd)
      cmd_pend <= 1'b0;
  end
  // report period, restarted by every accepted command
  assign rpt_wrap = (rpt_cnt == RPT_LAST);
  always_ff @(posedge i_mclk)
  begin
    if (i_reset || accept || (mode == SMCP_MODE_QUIET) || rpt_wrap)
      rpt_cnt <= 21'h000000;
    else
      rpt_cnt <= rpt_cnt + 21'h000001;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || accept || (mode == SMCP_MODE_QUIET))
      frame_due <= 1'b0;
    else if (rpt_wrap)
      frame_due <= 1'b1;
    else if (start_frame)
      frame_due <= 1'b0;
  end
  assign start_cmd   = !msg_busy && cmd_pend;
  assign start_frame = !msg_busy && !cmd_pend && frame_due && (mode != SMCP_MODE_QUIET);
  // message sequencer; a measurement snapshot is taken at message start
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      msg_busy <= 1'b0;
      msg_kind <= SMCP_MSG_ANN_QUIET;
      msg_idx  <= 5'h00;
      snap     <= '0;
    end
    else if (start_cmd || start_frame)
    begin
      msg_busy <= 1'b1;
      msg_idx  <= 5'h00;
      snap     <= i_meas;
      if (start_cmd)
        msg_kind <= cmd_kind;
      else if (mode == SMCP_MODE_FULL)
        msg_kind <= SMCP_MSG_FRM_FULL;
      else
        msg_kind <= SMCP_MSG_FRM_FLOW;
    end
    else if (msg_busy && tx_fire && !echo_pend)
    begin
      if (msg_idx == msg_last)
        msg_busy <= 1'b0;
      else
        msg_idx <= msg_idx + 5'h01;
    end
  end

  always_comb
  begin
    msg_byte = 8'h00;
    msg_last = 5'h00;
    case (msg_kind)
      SMCP_MSG_ANN_FULL:
      begin
        msg_last = 5'(`SMCP_LEN_ANN_FULL - 1);
        msg_byte = pick(TXT_W'(TXT_ANN_FULL), `SMCP_LEN_ANN_FULL, msg_idx);
      end
      SMCP_MSG_ANN_QUIET:
      begin
        msg_last = 5'(`SMCP_LEN_ANN_QUIET - 1);
        msg_byte = pick(TXT_W'(TXT_ANN_QUIET), `SMCP_LEN_ANN_QUIET, msg_idx);
      end
      SMCP_MSG_ANN_FLOW:
      begin
        msg_last = 5'(`SMCP_LEN_ANN_FLOW - 1);
        msg_byte = pick(TXT_W'(TXT_ANN_FLOW), `SMCP_LEN_ANN_FLOW, msg_idx);
      end
      SMCP_MSG_LOOKUP:
      begin
        msg_last = 5'(`SMCP_LEN_LOOKUP - 1);
        msg_byte = pick(TXT_LOOKUP, `SMCP_LEN_LOOKUP, msg_idx);
        if (int'(msg_idx) < `SMCP_LOOK_FLOW_POS + `SMCP_FLOW_DIGITS)
          msg_byte = flow_chr(snap.flow, int'(msg_idx) - `SMCP_LOOK_FLOW_POS);
      end
      SMCP_MSG_FRM_FULL:
      begin
        msg_last = 5'(`SMCP_LEN_FRM_FULL - 1);
        msg_byte = pick(TXT_W'(TXT_FRM_FULL), `SMCP_LEN_FRM_FULL, msg_idx);
        if ((int'(msg_idx) >= `SMCP_FULL_VOLT_POS) &&
            (int'(msg_idx) < `SMCP_FULL_VOLT_POS + `SMCP_VOLT_DIGITS))
          msg_byte = volt_chr(snap.volt, int'(msg_idx) - `SMCP_FULL_VOLT_POS);
        if ((int'(msg_idx) >= `SMCP_FULL_FLOW_POS) &&
            (int'(msg_idx) < `SMCP_FULL_FLOW_POS + `SMCP_FLOW_DIGITS))
          msg_byte = flow_chr(snap.flow, int'(msg_idx) - `SMCP_FULL_FLOW_POS);
      end
      SMCP_MSG_FRM_FLOW:
      begin
        msg_last = 5'(`SMCP_LEN_FRM_FLOW - 1);
        msg_byte = pick(TXT_W'(TXT_FRM_FLOW), `SMCP_LEN_FRM_FLOW, msg_idx);
        if ((int'(msg_idx) >= `SMCP_FLOW_FLOW_POS) &&
            (int'(msg_idx) < `SMCP_FLOW_FLOW_POS + `SMCP_FLOW_DIGITS))
          msg_byte = flow_chr(snap.flow, int'(msg_idx) - `SMCP_FLOW_FLOW_POS);
      end
      default:
        msg_last = 5'h00;
    endcase
  end

  assign tx_valid   = echo_pend || msg_busy;
  assign tx_data    = echo_pend ? echo_byte : msg_byte;
  assign tx_fire    = tx_valid && tx_ready;
  assign o_mode     = mode;
  assign o_msg_busy = msg_busy;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  AST_ECHO_PREFIX: assert property (
    prefix_hit |=> echo_pend && (echo_byte == 8'h9D) && (cmd_st == SMCP_CMD_ARMED))
    else $error("prefix not echoed");
  AST_FULL_CMD: assert property (
    accept && (rx_data == 8'h54) |=> (mode == SMCP_MODE_FULL) && echo_pend && cmd_pend &&
      (cmd_kind == SMCP_MSG_ANN_FULL) && (echo_byte == 8'h54))
    else $error("full mode command mishandled");
  AST_QUIET_CMD: assert property (
    accept && (rx_data == 8'h00) |=> (mode == SMCP_MODE_QUIET) && echo_pend &&
      (cmd_kind == SMCP_MSG_ANN_QUIET))
    else $error("quiet mode command mishandled");
  AST_FLOW_CMD: assert property (
    accept && (rx_data == 8'h56) |=> (mode == SMCP_MODE_FLOW) && echo_pend &&
      (cmd_kind == SMCP_MSG_ANN_FLOW))
    else $error("flow-only command mishandled");
  AST_LOOKUP_CMD: assert property (
    accept && (rx_data == 8'h55) |=> (mode == SMCP_MODE_QUIET) && echo_pend &&
      (cmd_kind == SMCP_MSG_LOOKUP))
    else $error("lookup command mishandled");
  AST_IGNORE_BAD: assert property (
    rx_valid && (cmd_st == SMCP_CMD_ARMED) && !code_ok |=>
      (cmd_st == SMCP_CMD_IDLE) && $stable(mode) && !$rose(echo_pend) && !$rose(cmd_pend))
    else $error("bad code not ignored");
  AST_QUIET_SILENT: assert property (
    (mode == SMCP_MODE_QUIET) |-> !frame_due && !start_frame)
    else $error("frame pending in quiet mode");
  AST_PERIOD: assert property (
    $rose(frame_due) |-> ($past(rpt_cnt) == RPT_LAST) && ($past(mode) != SMCP_MODE_QUIET))
    else $error("report frame off period");
  AST_FULL_A_FIELD: assert property (
    msg_busy && (msg_kind == SMCP_MSG_FRM_FULL) && (msg_idx == 5'h13) |->
      (msg_byte == 8'h41))
    else $error("full frame field misplaced");
  AST_FULL_FLOW_DIGIT: assert property (
    msg_busy && (msg_kind == SMCP_MSG_FRM_FULL) && (msg_idx == 5'h0A) |->
      (msg_byte == {4'h3, snap.flow[31:28]}))
    else $error("flow digit wrong");
  AST_LOOKUP_TEXT: assert property (
    msg_busy && (msg_kind == SMCP_MSG_LOOKUP) && (msg_idx == 5'h08) |-> (msg_byte == 8'h49))
    else $error("lookup answer lacks quiet announcement");
  AST_FLOW_TAIL: assert property (
    msg_busy && (msg_kind == SMCP_MSG_FRM_FLOW) && (msg_idx == 5'h0B) |-> (msg_byte == 8'h3B))
    else $error("flow frame tail wrong");

  COV_FULL_FRAME:   cover property (start_frame && (mode == SMCP_MODE_FULL));
  COV_FLOW_FRAME:   cover property (start_frame && (mode == SMCP_MODE_FLOW));
  COV_LOOKUP:       cover property (start_cmd && (cmd_kind == SMCP_MSG_LOOKUP));
  COV_ECHO_IN_MSG:  cover property (echo_pend && msg_busy && tx_fire);

endmodule

// *** smcp_top_tb.sv ***
// self-checking bench for the serial mode command interpreter
`timescale 1ns/1ps
`include "smcp_defs.svh"
module smcp_top_tb
  import smcp_pkg::*;
;
  localparam int    RPT    = 100000;
  localparam string ANN_FU = "IN OPERATION MODE ......\n\r";
  localparam string ANN_Q  = "IN USER MODE.....\n\r";
  localparam string ANN_FL = "IN CUSTOMER MODE.....\n\r";

  logic       i_mclk = 1'b0;
  logic       i_reset = 1'b1;
  smcp_meas_t i_meas = '{flow: 32'h01234567, volt: 20'h98765};
  logic       rx_line;
  logic       o_tx;
  smcp_mode_t o_mode;
  logic       o_msg_busy;
  int         err_count = 0;
  int         n_checks = 0;
  realtime    t0;

  always #50 i_mclk = ~i_mclk;

  smcp_top #(.REPORT_CYC(RPT)) i_dut (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_rx      (rx_line),
    .i_meas    (i_meas),
    .o_tx      (o_tx),
    .o_mode    (o_mode),
    .o_msg_busy(o_msg_busy)
  );

  smcp_host i_host (
    .i_mclk(i_mclk),
    .i_tx  (o_tx),
    .o_rx  (rx_line)
  );

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // bounded wait until n bytes have come back
  task automatic wait_n(input int n, input int lim);
    int c;
    c = 0;
    while (i_host.rxq.size() < n && c < lim)
    begin
      @(negedge i_mclk);
      c++;
    end
    if (i_host.rxq.size() < n)
    begin
      err_count++;
      $display("unexpected byte count: expected %0d, seen %0d", n, i_host.rxq.size());
      summarize();
    end
  endtask

  task automatic chk_msg(input string what, input string s, input int at);
    for (int k = 0; k < s.len(); k++)
      check(what, s[k], i_host.rxq[at + k]);
  endtask

  // delay from code echo to the first frame byte
  task automatic chk_time();
    int cyc;
    cyc = int'(($realtime - t0) / 100.0);
    n_checks++;
    if (cyc < RPT - 200 || cyc > RPT + 3000)
    begin
      err_count++;
      $display("unexpected frame delay: expected %0d, seen %0d", RPT, cyc);
    end
  endtask

  task automatic cmd(input logic [7:0] code);
    i_host.rxq.delete();
    i_host.send(`SMCP_PREFIX);
    i_host.gap();
    wait_n(1, 1000);
    check("prefix echo", `SMCP_PREFIX, i_host.rxq[0]);
    i_host.send(code);
    wait_n(2, 3000);
    check("code echo", code, i_host.rxq[1]);
    t0 = $realtime;
  endtask

  task automatic t_ignore();
    i_host.rxq.delete();
    i_host.send(8'h41);
    i_host.gap();
    i_host.send(`SMCP_PREFIX);
    i_host.gap();
    i_host.send(8'h12);
    repeat (5000) @(negedge i_mclk);
    check("echo count", 8'h01, 8'(i_host.rxq.size()));
    check("mode", 8'(SMCP_MODE_QUIET), 8'(o_mode));
    $display("test ignore done");
  endtask

  task automatic t_flow();
    cmd(`SMCP_CODE_FLOW);
    check("mode", 8'(SMCP_MODE_FLOW), 8'(o_mode));
    wait_n(26, 110000);
    chk_time();
    chk_msg("flow ann", ANN_FL, 2);
    wait_n(38, 40000);
    chk_msg("flow frame", "F=01234567\n;\n", 25);
    $display("test flow done");
  endtask

  task automatic t_quiet();
    cmd(`SMCP_CODE_QUIET);
    check("mode", 8'(SMCP_MODE_QUIET), 8'(o_mode));
    wait_n(21, 60000);
    chk_msg("quiet ann", ANN_Q, 2);
    check("busy", 8'h00, 8'(o_msg_busy));
    repeat (3000) @(negedge i_mclk);
    check("quiet count", 8'h15, 8'(i_host.rxq.size()));
    $display("test quiet done");
  endtask

  task automatic t_lookup();
    i_meas.flow = 32'h76543210;
    cmd(`SMCP_CODE_LOOKUP);
    check("mode", 8'(SMCP_MODE_QUIET), 8'(o_mode));
    wait_n(29, 80000);
    chk_msg("lookup", {"76543210", ANN_Q}, 2);
    repeat (RPT + 20000) @(negedge i_mclk);
    check("quiet count", 8'h1D, 8'(i_host.rxq.size()));
    check("busy", 8'h00, 8'(o_msg_busy));
    $display("test lookup done");
  endtask

  task automatic t_full();
    cmd(`SMCP_CODE_FULL);
    check("mode", 8'(SMCP_MODE_FULL), 8'(o_mode));
    wait_n(29, 110000);
    chk_time();
    chk_msg("full ann", ANN_FU, 2);
    wait_n(53, 70000);
    chk_msg("full frame", "V=98765\nF=76543210\nA=0\n;\n", 28);
    $display("test full done");
  endtask

  initial
  begin
    repeat (5) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (3) @(negedge i_mclk);
    check("idle line", 8'h01, 8'(o_tx));
    check("mode", 8'(SMCP_MODE_QUIET), 8'(o_mode));
    t_ignore();
    t_flow();
    t_quiet();
    t_lookup();
    t_full();
    summarize();
  end
endmodule

// *** smcp_uart.sv ***
// 8n1 serial receiver and transmitter
`timescale 1ns/1ps
`include "smcp_defs.svh"
module smcp_uart
  import smcp_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_rx,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_tx
);

  localparam logic [8:0] BIT_LAST  = 9'(`SMCP_BIT_CYC - 1);
  localparam logic [8:0] HALF_LAST = 9'(`SMCP_HALF_CYC - 1);
  localparam logic [2:0] BITS_LAST = 3'(`SMCP_DATA_BITS - 1);

  logic          rx_meta;
  logic          rx_sync;
  smcp_uart_st_t rx_st;
  logic [8:0]    rx_cnt;
  logic [2:0]    rx_bit;
  logic [7:0]    rx_shift;
  smcp_uart_st_t tx_st;
  logic [8:0]    tx_cnt;
  logic [2:0]    tx_bit;
  logic [7:0]    tx_shift;
  logic          tx_tick;

  // two-stage pin synchroniser
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= i_rx;
      rx_sync <= rx_meta;
    end
  end

  // receiver: start check at mid bit, then sample each bit centre
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      rx_st      <= SMCP_UART_IDLE;
      rx_cnt     <= 9'h000;
      rx_bit     <= 3'h0;
      rx_shift   <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      rx_cnt     <= rx_cnt + 9'h001;
      case (rx_st)
        SMCP_UART_IDLE:
        begin
          rx_cnt <= 9'h000;
          if (!rx_sync)
            rx_st <= SMCP_UART_START;
        end
        SMCP_UART_START:
          if (rx_cnt == HALF_LAST)
          begin
            rx_cnt <= 9'h000;
            rx_bit <= 3'h0;
            rx_st  <= rx_sync ? SMCP_UART_IDLE : SMCP_UART_DATA;
          end
        SMCP_UART_DATA:
          if (rx_cnt == BIT_LAST)
          begin
            rx_cnt   <= 9'h000;
            rx_shift <= {rx_sync, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == BITS_LAST)
              rx_st <= SMCP_UART_STOP;
          end
        SMCP_UART_STOP:
          if (rx_cnt == BIT_LAST)
          begin
            rx_st <= SMCP_UART_IDLE;
            // a bad stop bit drops the byte
            if (rx_sync)
            begin
              o_rx_valid <= 1'b1;
              o_rx_data  <= rx_shift;
            end
          end
        default:
          rx_st <= SMCP_UART_IDLE;
      endcase
    end
  end

  assign tx_tick    = (tx_cnt == BIT_LAST);
  assign o_tx_ready = (tx_st == SMCP_UART_IDLE);

  // transmitter: start bit, eight bits lsb first, one stop bit
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      tx_st    <= SMCP_UART_IDLE;
      tx_cnt   <= 9'h000;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
      o_tx     <= 1'b1;
    end
    else
    begin
      tx_cnt <= tx_tick ? 9'h000 : tx_cnt + 9'h001;
      case (tx_st)
        SMCP_UART_IDLE:
        begin
          tx_cnt <= 9'h000;
          if (i_tx_valid)
          begin
            tx_shift <= i_tx_data;
            tx_st    <= SMCP_UART_START;
            o_tx     <= 1'b0;
          end
        end
        SMCP_UART_START:
          if (tx_tick)
          begin
            tx_st  <= SMCP_UART_DATA;
            tx_bit <= 3'h0;
            o_tx   <= tx_shift[0];
          end
        SMCP_UART_DATA:
          if (tx_tick)
          begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= tx_bit + 3'h1;
            if (tx_bit == BITS_LAST)
            begin
              tx_st <= SMCP_UART_STOP;
              o_tx  <= 1'b1;
            end
            else
              o_tx <= tx_shift[1];
          end
        SMCP_UART_STOP:
          if (tx_tick)
            tx_st <= SMCP_UART_IDLE;
        default:
          tx_st <= SMCP_UART_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_TX_BIT_TIME: assert property (
    $changed(o_tx) |-> ($past(tx_cnt) == BIT_LAST) || ($past(tx_st) == SMCP_UART_IDLE))
    else $error("tx line changed off a bit boundary");

  AST_TX_STOP_HIGH: assert property (
    (tx_st == SMCP_UART_STOP) |-> o_tx)
    else $error("stop bit not high");

endmodule
